/* File: core/mrc_map.svh */
/*
 reset controller constants: register offsets, field positions, reset values, timing.
 included by the reset controller package users; definitions only.
*/
`ifndef MRC_MAP_SVH
`define MRC_MAP_SVH
`define MRC_OFS_FLAGS 8'h00
`define MRC_OFS_LVSEL 8'h04
`define MRC_OFS_LVCTL 8'h08
`define MRC_OFS_CTRL 8'h0c
`define MRC_OFS_STAT 8'h10
`define MRC_BIT_TRAP 7
`define MRC_BIT_WDOG 4
`define MRC_BIT_CHK 1
`define MRC_BIT_LV 0
`define MRC_CTRL_WDOPT 0
`define MRC_CTRL_LVDEF 1
`define MRC_CTRL_SWCHK 2
`define MRC_LVSEL_RST 8'h0e
`define MRC_LVCTL_RST 8'h00
`define MRC_WDEN_RST_A 8'h1a
`define MRC_WDEN_RST_B 8'h9a
`define MRC_IRQ_FLAG_RST 8'h00
`define MRC_IRQ_MASK_RST 8'hff
`define MRC_TMR_CNT_RST 16'hffff
`define MRC_TMR_ZERO_RST 16'h0000
`define MRC_SER_SCR_RST 16'h0087
`define MRC_SER_SMR_RST 16'h0020
`define MRC_SER_SO_RST 16'h0f0f
`define MRC_VEC_LO 16'h0000
`define MRC_VEC_HI 16'h0001
`define MRC_ILLEGAL_OP 8'hff
`define MRC_EXT_MIN_NS 10000
`define MRC_PROC_NS 1000
`define MRC_OSC_NS 2000
`define MRC_CLK_NS 4
`endif

/* File: core/mrc_pkg.sv */
/*
 types for the reset controller.
 assumes nothing of its surroundings.
*/
package mrc_pkg;
   typedef enum logic [2:0] {
      MRC_SRC_PIN, MRC_SRC_POC, MRC_SRC_TRAP, MRC_SRC_WDOG, MRC_SRC_CHK, MRC_SRC_LV
   } mrc_src_t;
   typedef enum logic [1:0] {MRC_ST_HOLD, MRC_ST_PROC, MRC_ST_OSC, MRC_ST_RUN} mrc_state_t;
endpackage : mrc_pkg

/* File: core/mrc_reset_ctrl.sv */
/*
 reset controller: merges six reset causes, sequences release, keeps source flags,
 drives per-source init of detector and peripheral reset values; axi4-lite slave.
 assumes aclk is the internal high-speed oscillator clock and that cause inputs
 from the cpu, watchdog and check logic are synchronous; the pin and detector levels
 are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mrc_map.svh"
module mrc_reset_ctrl #(
   parameter int PROC_CYC = (`MRC_PROC_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS,
   parameter int OSC_CYC = (`MRC_OSC_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic reset_pin_n,
   input wire logic power_on_clear_detector,
   input wire logic low_voltage_detector,
   input wire logic watchdog_overflow,
   input wire logic check_error,
   input wire logic opcode_valid,
   input wire logic [7:0] opcode,
   input wire logic debug_emulation,
   input wire logic stop_mode,
   output logic core_reset_n,
   output logic cpu_clk_en,
   output logic osc_en,
   output logic ext_clk_accept,
   output logic periph_halt,
   output logic pin_hiz,
   output logic pc_undefined,
   output logic ram_hold,
   output logic [15:0] fetch_addr,
   output logic wdog_counter_init,
   output logic low_voltage_detector_run,
   output logic [7:0] watchdog_enable_register,
   output logic [7:0] low_voltage_level_select,
   output logic [7:0] low_voltage_control,
   output logic [7:0] irq_flag_rst,
   output logic [7:0] irq_mask_rst,
   output logic [15:0] tmr_cnt_rst,
   output logic [15:0] tmr_zero_rst,
   output logic [15:0] ser_scr_rst,
   output logic [15:0] ser_smr_rst,
   output logic [15:0] ser_so_rst
);
   // three-stage sampling of asynchronous levels: pin, poc, lv
   logic [2:0] s1_q, s2_q, s3_q, filt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 3'h7;
         s2_q <= 3'h7;
         s3_q <= 3'h7;
      end else begin
         s1_q <= {~reset_pin_n, power_on_clear_detector, low_voltage_detector};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         always_ff @(posedge aclk) begin
            if (!aresetn) filt_q[gi] <= 1'b1;
            else if (s2_q[gi] == s3_q[gi]) filt_q[gi] <= s3_q[gi];
         end
      end
   endgenerate
   wire pin_low = filt_q[2];
   wire poc_low = filt_q[1];
   wire lv_low = filt_q[0];
   // illegal opcode trap suppressed under emulation
   wire trap_hit = opcode_valid && (opcode == `MRC_ILLEGAL_OP) && !debug_emulation;

   logic [7:0] ctrl_q;
   wire chk_hit = check_error || ctrl_q[`MRC_CTRL_SWCHK];
   wire any_cause = pin_low | poc_low | lv_low | watchdog_overflow | chk_hit | trap_hit;

   // held causes (pin, detectors) keep hold; pulse causes release themselves
   wire held_cause = pin_low | poc_low | lv_low;

   mrc_pkg::mrc_state_t st_q, st_d;
   logic [15:0] cnt_q;
   wire cnt_done = (cnt_q == 16'h0000);
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         mrc_pkg::MRC_ST_HOLD: if (!held_cause) st_d = mrc_pkg::MRC_ST_PROC;
         mrc_pkg::MRC_ST_PROC: if (cnt_done) st_d = mrc_pkg::MRC_ST_OSC;
         mrc_pkg::MRC_ST_OSC: if (cnt_done) st_d = mrc_pkg::MRC_ST_RUN;
         mrc_pkg::MRC_ST_RUN: st_d = mrc_pkg::MRC_ST_RUN;
      endcase
      if (any_cause) st_d = mrc_pkg::MRC_ST_HOLD;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= mrc_pkg::MRC_ST_HOLD;
         cnt_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         if (st_d == mrc_pkg::MRC_ST_HOLD) cnt_q <= 16'(PROC_CYC - 1);
         else if (st_q == mrc_pkg::MRC_ST_PROC && cnt_done) cnt_q <= 16'(OSC_CYC - 1);
         else if (!cnt_done) cnt_q <= cnt_q - 16'h0001;
      end
   end

   // write path state, declared ahead of the registers it updates
   logic aw_have_q, w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   wire [7:0] wr_addr = aw_addr_q;
   wire wr_known = (wr_addr == `MRC_OFS_LVSEL) || (wr_addr == `MRC_OFS_LVCTL)
                   || (wr_addr == `MRC_OFS_CTRL);

   // last cause latched for source-dependent init
   logic lv_cause_q, wd_cause_q;
   logic [7:0] flags_q, lvsel_q, lvctl_q, wden_q;
   logic rd_clr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lv_cause_q <= 1'b0;
         wd_cause_q <= 1'b0;
      end else if (any_cause) begin
         lv_cause_q <= lv_low && !pin_low && !poc_low;
         wd_cause_q <= watchdog_overflow;
      end else if (st_q == mrc_pkg::MRC_ST_RUN) begin
         wd_cause_q <= 1'b0;
      end
   end

   // flags: cause setting wins over a read-clear in the same cycle
   logic [7:0] flags_d;
   always_comb begin
      flags_d = flags_q;
      if (rd_clr) flags_d = 8'h00;
      if (trap_hit) flags_d[`MRC_BIT_TRAP] = 1'b1;
      if (watchdog_overflow) flags_d[`MRC_BIT_WDOG] = 1'b1;
      if (chk_hit) flags_d[`MRC_BIT_CHK] = 1'b1;
      if (lv_low) flags_d[`MRC_BIT_LV] = 1'b1;
      if (pin_low || poc_low) flags_d = 8'h00;
   end
   wire in_reset = (st_q != mrc_pkg::MRC_ST_RUN);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= 8'h00;
         lvsel_q <= `MRC_LVSEL_RST;
         lvctl_q <= `MRC_LVCTL_RST;
         wden_q <= `MRC_WDEN_RST_A;
      end else begin
         flags_q <= flags_d;
         if (in_reset) begin
            if (!lv_cause_q) lvsel_q <= `MRC_LVSEL_RST;
            lvctl_q <= `MRC_LVCTL_RST | {7'h00, lv_cause_q & ctrl_q[`MRC_CTRL_LVDEF]};
            wden_q <= ctrl_q[`MRC_CTRL_WDOPT] ? `MRC_WDEN_RST_B : `MRC_WDEN_RST_A;
         end else begin
            // captured beat, the bus may already carry the next one
            if (wr_go && wr_addr == `MRC_OFS_LVSEL && w_strb_q[0]) lvsel_q <= w_data_q[7:0];
            if (wr_go && wr_addr == `MRC_OFS_LVCTL && w_strb_q[0]) lvctl_q <= w_data_q[7:0];
         end
      end
   end

   // axi4-lite slave; one write and one read outstanding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_q <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
            if (wr_addr == `MRC_OFS_CTRL && w_strb_q[0]) ctrl_q <= w_data_q[7:0];
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // software check-error request is a one-shot
         if (ctrl_q[`MRC_CTRL_SWCHK] && !(wr_go && wr_addr == `MRC_OFS_CTRL)) begin
            ctrl_q[`MRC_CTRL_SWCHK] <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire rd_take = s_axi_arvalid && !s_axi_rvalid;
   wire [7:0] st_word = {5'h00, in_reset, lv_cause_q, wd_cause_q};
   logic [31:0] rd_word;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `MRC_OFS_FLAGS: rd_word = {24'h0, flags_q};
         `MRC_OFS_LVSEL: rd_word = {24'h0, lvsel_q};
         `MRC_OFS_LVCTL: rd_word = {24'h0, lvctl_q};
         `MRC_OFS_CTRL: rd_word = {24'h0, ctrl_q};
         `MRC_OFS_STAT: rd_word = {24'h0, st_word};
         default: begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end
   assign rd_clr = rd_take && (s_axi_araddr == `MRC_OFS_FLAGS);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // reset fan-out; all registered, outputs decoded from st_d switch on the edge st_q changes, ram_hold and wdog_counter_init release one edge later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_reset_n <= 1'b0;
         cpu_clk_en <= 1'b0;
         osc_en <= 1'b0;
         ext_clk_accept <= 1'b0;
         periph_halt <= 1'b1;
         pin_hiz <= 1'b1;
         pc_undefined <= 1'b1;
         ram_hold <= 1'b1;
         fetch_addr <= `MRC_VEC_LO;
         wdog_counter_init <= 1'b0;
         low_voltage_detector_run <= 1'b0;
      end else begin
         core_reset_n <= (st_d == mrc_pkg::MRC_ST_RUN);
         cpu_clk_en <= (st_d == mrc_pkg::MRC_ST_RUN);
         osc_en <= (st_d != mrc_pkg::MRC_ST_HOLD);
         ext_clk_accept <= (st_d != mrc_pkg::MRC_ST_HOLD);
         periph_halt <= (st_d != mrc_pkg::MRC_ST_RUN);
         pin_hiz <= (st_d != mrc_pkg::MRC_ST_RUN);
         pc_undefined <= (st_d != mrc_pkg::MRC_ST_RUN);
         // ram held in stop mode and in reset unless supply falls below poc level
         ram_hold <= !poc_low && (stop_mode || in_reset || (st_d != mrc_pkg::MRC_ST_RUN));
         fetch_addr <= (st_d == mrc_pkg::MRC_ST_RUN) ? `MRC_VEC_HI : `MRC_VEC_LO;
         wdog_counter_init <= watchdog_overflow || (wd_cause_q && in_reset);
         low_voltage_detector_run <= (st_d == mrc_pkg::MRC_ST_RUN) || lv_low;
      end
   end
   // init values offered to peripherals while core_reset_n is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_flag_rst <= `MRC_IRQ_FLAG_RST;
         irq_mask_rst <= `MRC_IRQ_MASK_RST;
         tmr_cnt_rst <= `MRC_TMR_CNT_RST;
         tmr_zero_rst <= `MRC_TMR_ZERO_RST;
         ser_scr_rst <= `MRC_SER_SCR_RST;
         ser_smr_rst <= `MRC_SER_SMR_RST;
         ser_so_rst <= `MRC_SER_SO_RST;
         watchdog_enable_register <= `MRC_WDEN_RST_A;
         low_voltage_level_select <= `MRC_LVSEL_RST;
         low_voltage_control <= `MRC_LVCTL_RST;
      end else begin
         watchdog_enable_register <= wden_q;
         low_voltage_level_select <= lvsel_q;
         low_voltage_control <= lvctl_q;
      end
   end
endmodule : mrc_reset_ctrl
`default_nettype wire

/* File: sim/mrc_far_end.sv */
/*
 far-end model: external reset pin driver and the cpu's executed opcodes.
 assumes pin_req and trap_req are one-cycle pulses from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module mrc_far_end #(
   parameter int PIN_LOW = 12
) (
   input wire logic aclk,
   input wire logic core_reset_n,
   input wire logic pin_req,
   input wire logic trap_req,
   output logic reset_pin_n,
   output logic opcode_valid,
   output logic [7:0] opcode
);
   int low_cnt;
   initial begin
      low_cnt = 0;
      reset_pin_n = 1'b1;
      opcode_valid = 1'b0;
      opcode = 8'h00;
   end
   // pin minimum scaled down, the real width would dominate the run
   always @(posedge aclk) begin
      low_cnt <= pin_req ? PIN_LOW : (low_cnt > 0 ? low_cnt - 1 : 0);
      reset_pin_n <= !pin_req && low_cnt <= 1;
      opcode_valid <= trap_req && core_reset_n;
      // idle bus keeps moving so no stale ffh lingers
      opcode <= trap_req ? 8'hff : opcode + 8'h35;
   end
endmodule : mrc_far_end
`default_nettype wire

/* File: sim/mrc_reset_ctrl_props.sv */
/*
 port checker for the reset controller: holds in reset and reactions to causes.
 assumes it is bound onto mrc_reset_ctrl, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic reset_pin_n,
   input wire logic low_voltage_detector,
   input wire logic watchdog_overflow,
   input wire logic opcode_valid,
   input wire logic [7:0] opcode,
   input wire logic debug_emulation,
   input wire logic stop_mode,
   input wire logic core_reset_n,
   input wire logic cpu_clk_en,
   input wire logic osc_en,
   input wire logic ext_clk_accept,
   input wire logic periph_halt,
   input wire logic pin_hiz,
   input wire logic pc_undefined,
   input wire logic ram_hold,
   input wire logic [15:0] fetch_addr,
   input wire logic wdog_counter_init,
   input wire logic low_voltage_detector_run
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // eight cycles covers the three-flop sampler plus the sequencer
   sequence s_pin_low;
      !reset_pin_n [*8];
   endsequence
   sequence s_trap;
      opcode_valid && opcode == 8'hff && !debug_emulation && core_reset_n;
   endsequence
   property p_pin;
      s_pin_low |-> !core_reset_n;
   endproperty
   a_pin: assert property (p_pin) else $error("pin low without reset");
   property p_osc;
      s_pin_low |-> !osc_en && !ext_clk_accept;
   endproperty
   a_osc: assert property (p_osc) else $error("clock alive in pin reset");
   property p_ram;
      (stop_mode && !reset_pin_n) [*8] |-> ram_hold;
   endproperty
   a_ram: assert property (p_ram) else $error("ram not held");
   property p_hold;
      !core_reset_n |-> pin_hiz && periph_halt && !cpu_clk_en;
   endproperty
   a_hold: assert property (p_hold) else $error("not halted in reset");
   property p_pc;
      !core_reset_n ##1 !core_reset_n |-> pc_undefined && fetch_addr == 16'h0000;
   endproperty
   a_pc: assert property (p_pc) else $error("fetch state wrong in reset");
   property p_trap;
      s_trap |-> ##[1:4] !core_reset_n;
   endproperty
   a_trap: assert property (p_trap) else $error("trap opcode ignored");
   property p_wdog;
      watchdog_overflow && core_reset_n |-> ##[1:4] (!core_reset_n && wdog_counter_init);
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
   property p_lv;
      low_voltage_detector [*8] |-> low_voltage_detector_run;
   endproperty
   a_lv: assert property (p_lv) else $error("detector stopped in lv reset");
endmodule : mrc_reset_ctrl_chk
bind mrc_reset_ctrl mrc_reset_ctrl_chk u_chk (.*);
`default_nettype wire

/* File: sim/mrc_reset_ctrl_tb.sv */
/*
 self-checking bench for the reset controller: register traffic and every cause.
 assumes the far-end model drives the reset pin and the executed opcodes.
*/
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, reset_pin_n, power_on_clear_detector, low_voltage_detector;
   logic watchdog_overflow, check_error, opcode_valid, debug_emulation, stop_mode;
   logic core_reset_n, cpu_clk_en, osc_en, ext_clk_accept, periph_halt, pin_hiz;
   logic pc_undefined, ram_hold, wdog_counter_init, low_voltage_detector_run;
   logic pin_req, trap_req;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   logic [7:0] s_axi_awaddr, s_axi_araddr, opcode, watchdog_enable_register;
   logic [7:0] low_voltage_level_select, low_voltage_control, irq_flag_rst, irq_mask_rst;
   logic [15:0] fetch_addr, tmr_cnt_rst, tmr_zero_rst, ser_scr_rst, ser_smr_rst, ser_so_rst;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
   logic [33:0] exp_q[$];
   int fail_count = 0;
   int compares = 0;
   int seed = 32'h0956;
   mrc_reset_ctrl #(.PROC_CYC(4), .OSC_CYC(4)) u_dut (.*);
   mrc_far_end #(.PIN_LOW(12)) u_far (.*);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic tally_and_finish;
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wait_core(input logic v);
      int n;
      n = 0;
      while (core_reset_n !== v && n < 300) begin
         @(posedge aclk);
         n++;
      end
      chk("core_reset_n", 64'(v), 64'(core_reset_n));
   endtask : wait_core
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      exp_q.push_back({32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge aclk);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic wd_reset;
      watchdog_overflow <= 1'b1;
      @(posedge aclk);
      watchdog_overflow <= 1'b0;
      wait_core(1'b0);
      chk("wdog_init", 64'h1, 64'(wdog_counter_init));
      wait_core(1'b1);
   endtask : wd_reset
   task automatic trap(input logic dbg);
      debug_emulation <= dbg;
      trap_req <= 1'b1;
      @(posedge aclk);
      trap_req <= 1'b0;
      repeat (5) @(posedge aclk);
   endtask : trap
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk("rdata", 64'(exp_q.pop_front()), 64'({s_axi_rresp, s_axi_rdata}));
      end
      if (s_axi_bvalid && s_axi_bready) begin
         chk("bresp", 64'(exp_q.pop_front()), 64'(s_axi_bresp));
      end
   end
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      tally_and_finish;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {power_on_clear_detector, low_voltage_detector, watchdog_overflow, check_error} = '0;
      {debug_emulation, stop_mode, pin_req, trap_req, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      wait_core(1'b1);
      chk("irq_tmr", 64'h00ff_ffff_0000,
         {16'h0, irq_flag_rst, irq_mask_rst, tmr_cnt_rst, tmr_zero_rst});
      chk("serial", 64'h0087_0020_0f0f, {16'h0, ser_scr_rst, ser_smr_rst, ser_so_rst});
      chk("init", 64'h1a_0e00, 64'({watchdog_enable_register, low_voltage_level_select,
         low_voltage_control}));
      chk("fetch", 64'(fetch_addr), 64'h1);
      rd(8'h00, 34'h0);
      rd(8'h14, {2'b10, 32'h0});
      wr(8'h40, 32'h0, 2'b10);
      wr(8'h0c, 32'h1, 2'b00);
      wd_reset;
      chk("wden", 64'(watchdog_enable_register), 64'h9a);
      rd(8'h00, 34'h10);
      rd(8'h00, 34'h0);
      trap(1'b1);
      chk("dbg_core", 64'(core_reset_n), 64'h1);
      trap(1'b0);
      wait_core(1'b0);
      wait_core(1'b1);
      rnd = $random(seed);
      wr(8'h04, rnd, 2'b00);
      low_voltage_detector <= 1'b1;
      wait_core(1'b0);
      repeat (4) @(posedge aclk);
      chk("lv_run", 64'(low_voltage_detector_run), 64'h1);
      low_voltage_detector <= 1'b0;
      wait_core(1'b1);
      rd(8'h04, 34'(rnd[7:0]));
      check_error <= 1'b1;
      @(posedge aclk);
      check_error <= 1'b0;
      wait_core(1'b0);
      chk("lv_stop", 64'(low_voltage_detector_run), 64'h0);
      wait_core(1'b1);
      rd(8'h00, 34'h81 | 34'h02);
      rd(8'h04, 34'h0e);
      wd_reset;
      power_on_clear_detector <= 1'b1;
      wait_core(1'b0);
      power_on_clear_detector <= 1'b0;
      wait_core(1'b1);
      rd(8'h00, 34'h0);
      wd_reset;
      stop_mode <= 1'b1;
      pin_req <= 1'b1;
      @(posedge aclk);
      pin_req <= 1'b0;
      wait_core(1'b0);
      repeat (4) @(posedge aclk);
      chk("ram_hold", 64'(ram_hold), 64'h1);
      stop_mode <= 1'b0;
      wait_core(1'b1);
      rd(8'h00, 34'h0);
      tally_and_finish;
   end
endmodule : mrc_reset_ctrl_tb
`default_nettype wire
